// File: hw/ldsh_exec.sv
// Execute unit for signed halfword, unprivileged loads and shift alias
//
// Summary of operation
// - register offset is index shifted 0..3
// - halfword loads sign-extend to 32 bits
// - 16-bit register form uses no shift
// - 32-bit two-bit field gives shift 0..3
// - base plus offset, never written back
// - base all ones means literal halfword load
// - register-form destination all ones means related encoding
// - unprivileged word base all ones: literal
// - wide forms not literal or related are undefined without main extension
// - destination 13 or index 13/15 invalid
// - unprivileged destination 13 or 15 invalid
// - unprivileged loads use user permissions
// - unprivileged address base plus zero-extended byte
// - word load writes four bytes unchanged
// - failed checks raise the matching fault
// - shift alias fills low bits with zeros
// - shift count 1..31 from its fields
`default_nettype none
module ldsh_exec
    import ldsh_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Configuration
    input wire logic main_extension_present,
    // Issue from the core
    input wire logic issue_valid,
    output logic issue_ready,
    input wire logic [31:0] instr,
    input wire logic is_wide,
    input wire logic cond_passed,
    // Register file read (combinational, by field)
    output logic [3:0] rd_base_sel,
    output logic [3:0] rd_index_sel,
    input wire logic [DATA_W-1:0] rd_base_data,
    input wire logic [DATA_W-1:0] rd_index_data,
    // Memory request
    output logic mem_req,
    output logic [DATA_W-1:0] mem_addr,
    output logic [1:0] mem_size,
    output logic mem_unpriv,
    input wire logic mem_ack,
    input wire logic [DATA_W-1:0] mem_rdata,
    input wire logic mem_bus_err,
    input wire logic mem_mpu_err,
    input wire logic mem_sec_err,
    // Register writeback
    output logic wb_valid,
    output logic [3:0] wb_reg,
    output logic [DATA_W-1:0] wb_data,
    // Completion and status
    output logic done,
    output logic redirect,
    output dec_result_t redirect_kind,
    output logic fault_valid,
    output fault_t fault_kind
);
    op_kind_t kind;
    dec_result_t result;
    logic [3:0] dst;
    logic [3:0] base;
    logic [3:0] index;
    logic [4:0] shamt;
    logic [7:0] offset8;
    exec_state_t state;
    op_kind_t held_kind;
    logic [3:0] held_dst;
    logic accept;
    logic [DATA_W-1:0] next_addr;

    // Half-word sign extension, shared by both halfword loads
    function automatic logic [DATA_W-1:0] sext_half(
        input logic [DATA_W-1:0] d);
        sext_half = {{(DATA_W-16){d[HALF_SIGN_BIT]}}, d[15:0]};
    endfunction : sext_half

    ldsh_decode u_decode (
        .instr(instr),
        .is_wide(is_wide),
        .main_extension_present(main_extension_present),
        .kind(kind),
        .result(result),
        .destination_field(dst),
        .base_field(base),
        .index_field(index),
        .shift_amount(shamt),
        .byte_offset_field(offset8)
    );

    assign rd_base_sel = base;
    assign rd_index_sel = index;
    assign issue_ready = (state == ST_IDLE);
    assign accept = issue_valid && issue_ready;

    // Effective address; addition only, base is never updated
    always_comb begin
        next_addr = '0;
        if (kind == OP_SH_REG) begin
            next_addr = rd_base_data + (rd_index_data << shamt);
        end else if (kind == OP_UNP_SH || kind == OP_UNP_W) begin
            next_addr = rd_base_data + {{(DATA_W-8){1'b0}}, offset8};
        end
    end

    // Sequencer: one load outstanding at a time keeps ordering trivial
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept && cond_passed && result == DEC_OK &&
                        kind != OP_SHIFT && kind != OP_NONE) begin
                        state <= ST_WAIT;
                    end else if (accept) begin
                        state <= ST_DONE;
                    end
                end
                ST_WAIT: begin
                    if (mem_ack) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Memory request fields held for the whole access
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_req <= 1'b0;
            mem_addr <= '0;
            mem_size <= SIZE_HALF;
            mem_unpriv <= 1'b0;
            held_kind <= OP_NONE;
            held_dst <= 4'h0;
        end else if (state == ST_IDLE && accept) begin
            // a failed condition never starts an access
            mem_req <= cond_passed && result == DEC_OK &&
                       kind != OP_SHIFT && kind != OP_NONE;
            mem_addr <= next_addr;
            mem_size <= (kind == OP_UNP_W) ? SIZE_WORD : SIZE_HALF;
            mem_unpriv <= (kind == OP_UNP_SH || kind == OP_UNP_W);
            held_kind <= kind;
            held_dst <= dst;
        end else if (state == ST_WAIT && mem_ack) begin
            mem_req <= 1'b0;
        end
    end

    // Writeback, faults and completion, all one-cycle pulses
    always_ff @(posedge clk) begin
        if (reset) begin
            wb_valid <= 1'b0;
            wb_reg <= 4'h0;
            wb_data <= '0;
            done <= 1'b0;
            redirect <= 1'b0;
            redirect_kind <= DEC_OK;
            fault_valid <= 1'b0;
            fault_kind <= FLT_NONE;
        end else begin
            wb_valid <= 1'b0;
            done <= 1'b0;
            redirect <= 1'b0;
            fault_valid <= 1'b0;
            if (accept) begin
                wb_reg <= dst;
                if (!cond_passed) begin
                    done <= 1'b1;
                end else if (result == DEC_UNDEF ||
                             result == DEC_UNPRED) begin
                    // Invalid encodings are trapped, not executed
                    fault_valid <= 1'b1;
                    fault_kind <= FLT_USE;
                    done <= 1'b1;
                end else if (result != DEC_OK || kind == OP_NONE) begin
                    redirect <= 1'b1;
                    redirect_kind <= result;
                    done <= 1'b1;
                end else if (kind == OP_SHIFT) begin
                    wb_valid <= 1'b1;
                    wb_data <= rd_index_data << shamt;
                    done <= 1'b1;
                end
            end else if (state == ST_WAIT && mem_ack) begin
                done <= 1'b1;
                wb_reg <= held_dst;
                if (mem_sec_err) begin
                    fault_valid <= 1'b1;
                    fault_kind <= FLT_SEC;
                end else if (mem_mpu_err) begin
                    fault_valid <= 1'b1;
                    fault_kind <= FLT_MEMP;
                end else if (mem_bus_err) begin
                    fault_valid <= 1'b1;
                    fault_kind <= FLT_BUS;
                end else begin
                    wb_valid <= 1'b1;
                    if (held_kind == OP_UNP_W) begin
                        wb_data <= mem_rdata;
                    end else begin
                        wb_data <= sext_half(mem_rdata);
                    end
                end
            end
        end
    end
endmodule : ldsh_exec
`default_nettype wire

// File: shared/ldsh_pkg.sv
// Package: encodings, fields and states for the load/shift decode unit
`default_nettype none
package ldsh_pkg;
    // 16-bit register-offset signed halfword load: bits 15:9
    localparam logic [6:0] OP16_SHL = 7'h2f;
    // 16-bit shift-left alias: bits 15:11, count nonzero
    localparam logic [4:0] OP16_SHIFT = 5'h00;
    // 32-bit first halfword opcodes, bits 15:4; the shift alias matches all 16 bits
    localparam logic [11:0] OP32_SHL = 12'hf93;
    localparam logic [11:0] OP32_UNP_SH = 12'hf93;
    localparam logic [11:0] OP32_UNP_W = 12'hf85;
    localparam logic [15:0] OP32_SHIFT_HI = 16'hea4f;
    // Second halfword sub-fields
    localparam logic [5:0] SUB_REGOFF = 6'h00;
    localparam logic [3:0] SUB_UNPRIV = 4'he;
    localparam logic [3:0] REG_ALL_ONES = 4'hf;
    localparam logic [3:0] REG_SP = 4'hd;
    localparam logic [3:0] REG_PC = 4'hf;
    localparam logic [1:0] SHIFT_NONE = 2'h0;
    localparam logic [1:0] SHIFT_TYPE_LEFT = 2'h0;
    // Memory access sizes
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam int HALF_SIGN_BIT = 15;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_SH_REG = 3'b001,
        OP_UNP_SH = 3'b010,
        OP_UNP_W = 3'b011,
        OP_SHIFT = 3'b100
    } op_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } exec_state_t;

    // Decode outcome reported to the core
    typedef enum logic [2:0] {
        DEC_OK = 3'b000,
        DEC_LITERAL_SH = 3'b001,
        DEC_LITERAL_W = 3'b010,
        DEC_RELATED = 3'b011,
        DEC_UNDEF = 3'b100,
        DEC_UNPRED = 3'b101,
        DEC_OTHER = 3'b110
    } dec_result_t;

    // Fault classes
    typedef enum logic [2:0] {
        FLT_NONE = 3'b000,
        FLT_USE = 3'b001,
        FLT_BUS = 3'b010,
        FLT_MEMP = 3'b011,
        FLT_SEC = 3'b100
    } fault_t;
endpackage : ldsh_pkg
`default_nettype wire

// File: hw/ldsh_decode.sv
// Combinational decoder for the load and shift-alias group
`default_nettype none
module ldsh_decode
    import ldsh_pkg::*;
(
    // Instruction
    input wire logic [31:0] instr,
    input wire logic is_wide,
    input wire logic main_extension_present,
    // Decoded fields
    output op_kind_t kind,
    output dec_result_t result,
    output logic [3:0] destination_field,
    output logic [3:0] base_field,
    output logic [3:0] index_field,
    output logic [4:0] shift_amount,
    output logic [7:0] byte_offset_field
);
    logic [15:0] hw1;
    logic [15:0] hw2;

    assign hw1 = instr[31:16];
    assign hw2 = instr[15:0];

    // Field extraction and classification
    always_comb begin
        kind = OP_NONE;
        result = DEC_OTHER;
        destination_field = 4'h0;
        base_field = 4'h0;
        index_field = 4'h0;
        shift_amount = 5'h00;
        byte_offset_field = 8'h00;
        if (!is_wide) begin
            if (instr[15:9] == OP16_SHL) begin
                kind = OP_SH_REG;
                result = DEC_OK;
                index_field = {1'b0, instr[8:6]};
                base_field = {1'b0, instr[5:3]};
                destination_field = {1'b0, instr[2:0]};
                shift_amount = 5'h00;
            end else if (instr[15:11] == OP16_SHIFT &&
                         instr[10:6] != 5'h00) begin
                kind = OP_SHIFT;
                result = DEC_OK;
                shift_amount = instr[10:6];
                index_field = {1'b0, instr[5:3]};
                destination_field = {1'b0, instr[2:0]};
            end
        end else if (hw1[15:4] == OP32_SHL &&
                     hw2[11:6] == SUB_REGOFF) begin
            kind = OP_SH_REG;
            base_field = hw1[3:0];
            destination_field = hw2[15:12];
            index_field = hw2[3:0];
            shift_amount = {3'h0, hw2[5:4]};
            if (base_field == REG_ALL_ONES) begin
                result = DEC_LITERAL_SH;
            end else if (destination_field == REG_ALL_ONES) begin
                result = DEC_RELATED;
            end else if (!main_extension_present) begin
                result = DEC_UNDEF;
            end else if (destination_field == REG_SP ||
                         index_field == REG_SP ||
                         index_field == REG_PC) begin
                result = DEC_UNPRED;
            end else begin
                result = DEC_OK;
            end
        end else if ((hw1[15:4] == OP32_UNP_SH ||
                      hw1[15:4] == OP32_UNP_W) &&
                     hw2[11:8] == SUB_UNPRIV) begin
            kind = (hw1[15:4] == OP32_UNP_W) ? OP_UNP_W : OP_UNP_SH;
            base_field = hw1[3:0];
            destination_field = hw2[15:12];
            byte_offset_field = hw2[7:0];
            if (base_field == REG_ALL_ONES) begin
                result = (kind == OP_UNP_W) ? DEC_LITERAL_W
                                            : DEC_LITERAL_SH;
            end else if (!main_extension_present) begin
                result = DEC_UNDEF;
            end else if (destination_field == REG_SP ||
                         destination_field == REG_PC) begin
                result = DEC_UNPRED;
            end else begin
                result = DEC_OK;
            end
        end else if (hw1 == OP32_SHIFT_HI && hw2[15] == 1'b0 &&
                     hw2[5:4] == SHIFT_TYPE_LEFT &&
                     {hw2[14:12], hw2[7:6]} != 5'h00) begin
            kind = OP_SHIFT;
            destination_field = hw2[11:8];
            index_field = hw2[3:0];
            shift_amount = {hw2[14:12], hw2[7:6]};
            result = main_extension_present ? DEC_OK : DEC_UNDEF;
        end
    end
endmodule : ldsh_decode
`default_nettype wire

// File: verification/ldsh_chk.sv
// Concurrent checks on the load and shift execute unit ports
`default_nettype none
module ldsh_chk
    import ldsh_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Memory side
    input wire logic mem_req,
    input wire logic [DATA_W-1:0] mem_addr,
    input wire logic [1:0] mem_size,
    input wire logic mem_unpriv,
    input wire logic mem_ack,
    input wire logic [DATA_W-1:0] mem_rdata,
    input wire logic mem_bus_err,
    input wire logic mem_mpu_err,
    input wire logic mem_sec_err,
    // Results
    input wire logic wb_valid,
    input wire logic [DATA_W-1:0] wb_data,
    input wire logic done,
    input wire logic fault_valid,
    input wire fault_t fault_kind
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic fin;
    logic err;
    // Acknowledge seen on a live request, and whether it carried an error
    assign fin = mem_req && mem_ack;
    assign err = mem_bus_err || mem_mpu_err || mem_sec_err;

    // Attributes must not move while the memory side may still sample them
    chk_req_holds: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_size) && $stable(mem_unpriv))
        else $error("memory request changed before acknowledge");
    chk_ack_done: assert property (fin |=> done ##1 !done)
        else $error("done not a single pulse after acknowledge");
    chk_word_unpriv: assert property (mem_req && mem_size == SIZE_WORD
        |-> mem_unpriv) else $error("word load without user attribute");
    chk_half_sign: assert property (fin && !err && mem_size == SIZE_HALF
        |=> wb_valid && wb_data ==
        {{16{$past(mem_rdata[15])}}, $past(mem_rdata[15:0])})
        else $error("halfword result not sign-extended");
    chk_word_copy: assert property (fin && !err && mem_size == SIZE_WORD
        |=> wb_valid && wb_data == $past(mem_rdata))
        else $error("word result differs from memory data");
    chk_sec_first: assert property (fin && mem_sec_err
        |=> fault_valid && fault_kind == FLT_SEC)
        else $error("security error not reported first");
    chk_mpu_next: assert property (fin && mem_mpu_err && !mem_sec_err
        |=> fault_valid && fault_kind == FLT_MEMP)
        else $error("protection error misreported");
    chk_bus_last: assert property (fin && err && !mem_mpu_err
        && !mem_sec_err |=> fault_valid && fault_kind == FLT_BUS)
        else $error("bus error misreported");
    chk_fault_no_wb: assert property (fault_valid |-> !wb_valid)
        else $error("writeback alongside a fault");
endmodule : ldsh_chk

bind ldsh_exec ldsh_chk #(.DATA_W(DATA_W)) u_ldsh_chk (.clk(clk),
    .reset(reset), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_size(mem_size), .mem_unpriv(mem_unpriv), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_bus_err(mem_bus_err),
    .mem_mpu_err(mem_mpu_err), .mem_sec_err(mem_sec_err),
    .wb_valid(wb_valid), .wb_data(wb_data), .done(done),
    .fault_valid(fault_valid), .fault_kind(fault_kind));
`default_nettype wire

// File: verification/ldsh_mem_model.sv
// Memory-side model answering load requests after a set wait
`default_nettype none
module ldsh_mem_model #(
    parameter logic [31:0] MASK = 32'h9e37_8c15
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Request from the load unit
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    // Wait states and error select {security, protection, bus}
    input wire logic [3:0] delay,
    input wire logic [2:0] err_sel,
    // Answer
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic mem_bus_err,
    output logic mem_mpu_err,
    output logic mem_sec_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waited;
    // One-cycle acknowledge; idle data toggles so stale data never matches
    always_ff @(posedge clk) begin
        mem_rdata <= ~mem_rdata;
        if (reset || mem_ack) begin
            mem_ack <= 1'b0;
            waited <= 4'h0;
            if (reset)
                mem_rdata <= MASK;
        end else if (mem_req && waited == delay) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr ^ MASK;
        end else if (mem_req) begin
            waited <= waited + 4'h1;
        end
    end
    // Errors only qualify the acknowledge cycle
    assign {mem_sec_err, mem_mpu_err, mem_bus_err} = mem_ack ? err_sel : 3'h0;
endmodule : ldsh_mem_model
`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench for the load and shift-alias execute unit
`default_nettype none
module tb
    import ldsh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] MASK = 32'h9e37_8c15;
    logic clk = 1'b0, reset = 1'b1, main_extension_present = 1'b1;
    logic issue_valid = 1'b0, is_wide = 1'b0, cond_passed = 1'b1;
    logic [31:0] instr = 32'h0;
    logic [3:0] delay = 4'h0;
    logic [2:0] err_sel = 3'h0;
    logic issue_ready, mem_req, mem_unpriv, mem_ack, wb_valid, done;
    logic redirect, fault_valid, mem_bus_err, mem_mpu_err, mem_sec_err;
    logic [3:0] rd_base_sel, rd_index_sel, wb_reg;
    logic [31:0] rd_base_data, rd_index_data, mem_addr, mem_rdata, wb_data;
    logic [1:0] mem_size;
    dec_result_t redirect_kind;
    fault_t fault_kind;
    logic [31:0] regs [16];
    logic g_req, g_unpriv, g_wb, g_flt, g_red;
    logic [31:0] g_addr, g_wdata;
    logic [1:0] g_size;
    logic [3:0] g_wreg;
    logic [2:0] g_fk, g_rk;
    int error_cnt = 0, num_checks = 0;

    // Register file read is combinational, as the unit expects
    assign rd_base_data = regs[rd_base_sel];
    assign rd_index_data = regs[rd_index_sel];
    always #2 clk = ~clk;

    ldsh_exec #(.DATA_W(32)) u_ldsh_exec (.clk(clk), .reset(reset),
        .main_extension_present(main_extension_present),
        .issue_valid(issue_valid), .issue_ready(issue_ready),
        .instr(instr), .is_wide(is_wide), .cond_passed(cond_passed),
        .rd_base_sel(rd_base_sel), .rd_index_sel(rd_index_sel),
        .rd_base_data(rd_base_data), .rd_index_data(rd_index_data),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_size(mem_size),
        .mem_unpriv(mem_unpriv), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_bus_err(mem_bus_err), .mem_mpu_err(mem_mpu_err),
        .mem_sec_err(mem_sec_err), .wb_valid(wb_valid), .wb_reg(wb_reg),
        .wb_data(wb_data), .done(done), .redirect(redirect),
        .redirect_kind(redirect_kind), .fault_valid(fault_valid),
        .fault_kind(fault_kind));
    ldsh_mem_model #(.MASK(MASK)) u_ldsh_mem_model (.clk(clk),
        .reset(reset), .mem_req(mem_req), .mem_addr(mem_addr),
        .delay(delay), .err_sel(err_sel), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .mem_bus_err(mem_bus_err),
        .mem_mpu_err(mem_mpu_err), .mem_sec_err(mem_sec_err));

    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    // Offer one instruction, hold it until taken, collect the outcome
    task automatic issue(input logic [31:0] ins, input logic wide, cnd);
        int n;
        instr <= ins;
        is_wide <= wide;
        cond_passed <= cnd;
        issue_valid <= 1'b1;
        g_req = 1'b0;
        @(posedge clk);
        for (n = 0; n < 40 && issue_ready !== 1'b1; n++)
            @(posedge clk);
        issue_valid <= 1'b0;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (mem_req === 1'b1)
                {g_req, g_addr, g_size, g_unpriv} =
                    {1'b1, mem_addr, mem_size, mem_unpriv};
            if (done === 1'b1)
                break;
        end
        check(32'(n), 32'(n % 40));
        {g_wb, g_wreg, g_wdata, g_flt, g_fk, g_red, g_rk} = {wb_valid, wb_reg,
            wb_data, fault_valid, fault_kind, redirect, redirect_kind};
    endtask : issue

    task automatic expect_load(input logic [31:0] a, input logic [1:0] sz,
            input logic up, input logic [3:0] rt);
        logic [31:0] d;
        d = a ^ MASK;
        if (sz == SIZE_HALF)
            d = {{16{d[15]}}, d[15:0]};
        check(32'({g_req, g_wb, g_flt, g_wreg}), 32'({3'b110, rt}));
        check(g_addr, a);
        check(32'({g_size, g_unpriv}), 32'({sz, up}));
        check(g_wdata, d);
    endtask : expect_load

    // Outcomes without writeback: fault, redirect or a quiet finish
    task automatic outcome(input logic [31:0] ins, input logic wide, cnd,
            req, input logic [2:0] fk, rk);
        issue(ins, wide, cnd);
        check(32'({g_req, g_wb, g_flt, g_red}),
            32'({req, 1'b0, fk != 3'h0, rk != 3'h0}));
        if (fk != 3'h0)
            check(32'(g_fk), 32'(fk));
        if (rk != 3'h0)
            check(32'(g_rk), 32'(rk));
    endtask : outcome

    task automatic t_loads();
        // Short form works even without the main extension
        main_extension_present <= 1'b0;
        issue({16'h0, 7'h2f, 3'h5, 3'h3, 3'h1}, 1'b0, 1'b1);
        expect_load(regs[3] + regs[5], SIZE_HALF, 1'b0, 4'h1);
        main_extension_present <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            delay <= 4'(s * 3);
            issue({OP32_SHL, 4'h4, 4'h2, 6'h00, 2'(s), 4'h6}, 1'b1, 1'b1);
            expect_load(regs[4] + (regs[6] << s), SIZE_HALF, 1'b0,
                4'h2);
        end
        delay <= 4'h0;
        issue({OP32_UNP_SH, 4'h7, 4'h3, SUB_UNPRIV, 8'hff}, 1'b1, 1'b1);
        expect_load(regs[7] + 32'hff, SIZE_HALF, 1'b1, 4'h3);
        issue({OP32_UNP_W, 4'h8, 4'hc, SUB_UNPRIV, 8'h00}, 1'b1, 1'b1);
        expect_load(regs[8], SIZE_WORD, 1'b1, 4'hc);
    endtask : t_loads

    task automatic t_decode();
        // Full 32-bit encodings: first halfword high, second halfword low
        outcome(32'hf93f_2016, 1, 1, 0, 0, DEC_LITERAL_SH);
        outcome(32'hf93f_2e00, 1, 1, 0, 0, DEC_LITERAL_SH);
        outcome(32'hf85f_2e00, 1, 1, 0, 0, DEC_LITERAL_W);
        outcome(32'hf934_f016, 1, 1, 0, 0, DEC_RELATED);
        outcome(32'hf934_d016, 1, 1, 0, FLT_USE, 0);
        outcome(32'hf934_201f, 1, 1, 0, FLT_USE, 0);
        outcome(32'hf934_de04, 1, 1, 0, FLT_USE, 0);
        outcome(32'hf854_fe04, 1, 1, 0, FLT_USE, 0);
        outcome(32'hf934_2016, 1, 0, 0, 0, 0);
        main_extension_present <= 1'b0;
        outcome(32'hf934_2016, 1, 1, 0, FLT_USE, 0);
        outcome(32'hf854_2e04, 1, 1, 0, FLT_USE, 0);
        main_extension_present <= 1'b1;
        // Errors stacked so only the highest class may be reported
        foreach (regs[i]) if (i < 3) begin
            err_sel <= 3'b111 >> i;
            outcome(32'hf859_1e04, 1, 1, 1,
                3'(FLT_SEC - i), 0);
        end
        err_sel <= 3'h0;
    endtask : t_decode

    task automatic t_shift();
        logic [31:0] ins [3] = '{{16'h0, 5'h00, 5'd1, 3'h2, 3'h0},
            {16'h0, 5'h00, 5'd31, 3'h7, 3'h5},
            {16'hea4f, 1'b0, 3'h6, 4'ha, 2'h3, 2'h0, 4'hb}};
        logic [31:0] exp [3] = '{regs[2] << 1, regs[7] << 31, regs[11] << 27};
        logic [3:0] rd [3] = '{4'h0, 4'h5, 4'ha};
        for (int i = 0; i < 3; i++) begin
            issue(ins[i], 1'(i / 2), 1'b1);
            check(32'({g_req, g_wb, g_flt, g_wreg}),
                32'({3'b010, rd[i]}));
            check(g_wdata, exp[i]);
        end
        outcome(ins[1], 1'b0, 1'b0, 0, 0, 0);
        // A zero count is outside the alias and goes elsewhere
        outcome(32'h0000_0011, 1'b0, 1'b1, 0, 0, DEC_OTHER);
    endtask : t_shift

    task automatic summarize();
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        for (int i = 0; i < 16; i++)
            regs[i] = 32'h2000_8000 + (i << 12) + i * 32'h93;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_loads();
        t_decode();
        t_shift();
        summarize();
    end
    // Watchdog: whole run needs well under a thousand cycles
    initial begin
        #20000;
        error_cnt++;
        summarize();
    end
endmodule : tb
`default_nettype wire
